// ### rtl/nfhp_pkg.sv
package nfhp_pkg;

    // Clock and strobe timing
    localparam int CLK_NS         = 40;
    localparam int RD_CYC_HV_NS   = 20;
    localparam int RD_CYC_LV_NS   = 30;
    localparam int WE_LOW_NS      = 25;
    localparam int WE_HIGH_NS     = 15;
    localparam int REA_NS         = 30;
    localparam int SYNC_STAGES    = 2;
    // Worst read cycle sets each strobe phase, rounded up, never below one cycle
    localparam int RD_PHASE_CYC   = (RD_CYC_LV_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    localparam int WE_LOW_CYC     = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC    = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int REA_CYC        = (REA_NS + CLK_NS - 1) / CLK_NS;
    localparam int RE_LOW_RAW     = REA_CYC + SYNC_STAGES;
    localparam int RE_LOW_CYC     = (RE_LOW_RAW > RD_PHASE_CYC) ? RE_LOW_RAW : RD_PHASE_CYC;
    localparam int RE_HIGH_CYC    = RD_PHASE_CYC;
    localparam int SETTLE_CYC     = 4;

    // Array geometry and address layout
    localparam int BLOCKS         = 4096;
    localparam int PLANES         = 2;
    localparam int PAGES_PER_BLK  = 64;
    localparam int COL_W_X8       = 12;
    localparam int COL_W_X16      = 11;
    localparam int PAGE_W         = 6;
    localparam int BLOCK_W        = 12;
    localparam int ADDR_W         = 32;
    localparam int ADDR_IDX_COL0  = 0;
    localparam int ADDR_IDX_COL1  = 1;
    localparam int ADDR_IDX_ROW0  = 2;
    localparam int ADDR_IDX_ROW1  = 3;
    localparam int ADDR_IDX_LAST  = 4;
    localparam int CNT_W          = 4;
    localparam int IO_W           = 16;

    typedef enum logic [2:0]
    {
        OP_CMD,
        OP_ADDR_COL,
        OP_ADDR_ROW,
        OP_ADDR_FULL,
        OP_WRITE,
        OP_READ,
        OP_WAIT,
        OP_DESELECT
    } nfhp_op_type;

    typedef struct packed
    {
        nfhp_op_type          op;
        logic [IO_W-1:0]      data;
        logic [COL_W_X8-1:0]  col;
        logic [PAGE_W-1:0]    page;
        logic [BLOCK_W-1:0]   block;
    } nfhp_req_type;

    typedef struct packed
    {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
    } nfhp_ctl_type;

    localparam nfhp_ctl_type CTL_RESET = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                                           we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};

endpackage : nfhp_pkg

// ### rtl/nfhp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module nfhp_sync
#(
    parameter int W = 1
)
(
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = i_en ? i_d : meta_q;
        sync_d = i_en ? meta_q : sync_q;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;

endmodule : nfhp_sync

`default_nettype wire

// ### rtl/nfhp_host.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RQ1] Device latches io_bus on write strobe rise
// [RQ2] Command latch raised only during command cycles
// [RQ3] Address latch raised only for address bytes
// [RQ4] Device floats io_bus when deselected or unread
// [RQ5] Busy device ignores chip enable changes
// [RQ6] Read strobe fall outputs word, column advances
// [RQ7] Write protect low blocks program and erase
// [RQ8] Ready_busy_n wired line, low means busy
// [RQ9] Array holds 4096 blocks of 64 pages
// [RQ10] Two planes of 2048 blocks each
// [RQ11] Multi-plane: one page or block per plane
// [RQ12] Page program 200us, block erase 2ms typical
// [RQ13] Device runs program and erase internally
// [RQ14] Read strobe cycle no faster than 20/30ns
// [RQ15] Upper data byte only in 16-bit organisation
// [RQ16] x8 column bits 0-11 in first two cycles
// [RQ17] Address bit 18 selects plane or block
// [RQ18] Device holds ready_busy_n low while operating
module nfhp_host
    import nfhp_pkg::*;
#(
    parameter bit X16 = 1'b0
)
(
    input  wire logic            i_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_en,
    input  wire logic            i_wp_allow,
    input  wire logic            i_req_valid,
    output var  logic            o_req_ready,
    input  wire nfhp_req_type    i_req,
    output var  logic            o_rsp_valid,
    output var  logic [IO_W-1:0] o_rsp_data,
    output var  logic            o_ce_n,
    output var  logic            o_cle,
    output var  logic            o_ale,
    output var  logic            o_we_n,
    output var  logic            o_re_n,
    output var  logic            o_wp_n,
    output var  logic [IO_W-1:0] o_io_bus,
    output var  logic [IO_W-1:0] o_io_bus_oe_n,
    input  wire logic [IO_W-1:0] i_io_bus,
    input  wire logic            i_ready_busy_n
);

    localparam int          CW       = X16 ? COL_W_X16 : COL_W_X8;
    localparam logic [31:0] COL_MASK = (32'h1 << CW) - 32'h1;

    typedef enum logic [2:0]
    {
        S_IDLE,
        S_SETUP,
        S_WLOW,
        S_WHIGH,
        S_RLOW,
        S_RHIGH,
        S_SETTLE,
        S_WAIT
    } nfhp_state_type;

    nfhp_state_type   st_q, st_d;
    nfhp_ctl_type     ctl_q, ctl_d;
    nfhp_req_type     req_q, req_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0]       idx_q, idx_d;
    logic [2:0]       last_q, last_d;
    logic [IO_W-1:0]  io_q, io_d;
    logic             drive_q, drive_d;
    logic             wide_q, wide_d;
    logic             sel_q, sel_d;
    logic             rsp_valid_q, rsp_valid_d;
    logic [IO_W-1:0]  rsp_q, rsp_d;
    logic [IO_W-1:0]  io_sync;
    logic             rb_sync;

    nfhp_sync
    #(
        .W (IO_W + 1)
    )
    u_sync
    (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_en   (i_en),
        .i_d    ({i_ready_busy_n, i_io_bus}),
        .o_q    ({rb_sync, io_sync})
    );

    // Plane select falls on block bit 0, i.e. address bit 18 on x8
    function automatic logic [7:0] addr_byte(input nfhp_req_type r, input logic [2:0] idx);
        logic [31:0] a;
        logic [31:0] row;
        a   = (32'(r.block) << (PAGE_W + CW)) | (32'(r.page) << CW)
            | (32'(r.col) & COL_MASK); // RQ17
        row = a >> CW;
        unique case (idx)
            3'(ADDR_IDX_COL0): addr_byte = a[7:0]; // RQ16
            3'(ADDR_IDX_COL1): addr_byte = a[15:8] & COL_MASK[15:8]; // RQ16
            3'(ADDR_IDX_ROW0): addr_byte = row[7:0];
            3'(ADDR_IDX_ROW1): addr_byte = row[15:8];
            default:           addr_byte = row[23:16];
        endcase
    endfunction : addr_byte

    always_comb
    begin
        st_d        = st_q;
        ctl_d       = ctl_q;
        req_d       = req_q;
        cnt_d       = cnt_q;
        idx_d       = idx_q;
        last_d      = last_q;
        io_d        = io_q;
        drive_d     = drive_q;
        wide_d      = wide_q;
        sel_d       = sel_q;
        rsp_valid_d = 1'b0;
        rsp_d       = rsp_q;
        ctl_d.wp_n  = i_wp_allow; // RQ7
        // Chip stays selected across a whole sequence, including busy waits
        ctl_d.ce_n  = ~(sel_d || (st_q != S_IDLE));
        unique case (st_q)
            S_IDLE:
            begin
                if (i_req_valid)
                begin
                    req_d = i_req;
                    sel_d = 1'b1;
                    idx_d = 3'(ADDR_IDX_COL0);
                    last_d = 3'(ADDR_IDX_COL0);
                    unique case (i_req.op)
                        OP_CMD:
                        begin
                            ctl_d.cle = 1'b1; // RQ2
                            io_d      = {8'h00, i_req.data[7:0]};
                            drive_d   = 1'b1;
                            wide_d    = 1'b0;
                            st_d      = S_SETUP;
                        end
                        OP_ADDR_COL, OP_ADDR_ROW, OP_ADDR_FULL:
                        begin
                            ctl_d.ale = 1'b1; // RQ3
                            idx_d   = (i_req.op == OP_ADDR_ROW) ? 3'(ADDR_IDX_ROW0)
                                                               : 3'(ADDR_IDX_COL0);
                            last_d  = (i_req.op == OP_ADDR_COL) ? 3'(ADDR_IDX_COL1)
                                                               : 3'(ADDR_IDX_LAST);
                            io_d    = {8'h00, addr_byte(i_req, idx_d)};
                            drive_d = 1'b1;
                            wide_d  = 1'b0;
                            st_d    = S_SETUP;
                        end
                        OP_WRITE:
                        begin
                            io_d    = X16 ? i_req.data : {8'h00, i_req.data[7:0]};
                            drive_d = 1'b1;
                            wide_d  = X16; // RQ15
                            st_d    = S_SETUP;
                        end
                        OP_READ:
                        begin
                            ctl_d.re_n = 1'b0;
                            cnt_d      = CNT_W'(RE_LOW_CYC - 1); // RQ14
                            st_d       = S_RLOW;
                        end
                        OP_WAIT:
                        begin
                            cnt_d = CNT_W'(SETTLE_CYC - 1);
                            st_d  = S_SETTLE;
                        end
                        OP_DESELECT:
                        begin
                            sel_d       = 1'b0;
                            rsp_valid_d = 1'b1;
                        end
                    endcase
                    ctl_d.ce_n = ~(sel_d || (st_d != S_IDLE));
                end
            end
            S_SETUP:
            begin
                ctl_d.we_n = 1'b0;
                cnt_d      = CNT_W'(WE_LOW_CYC - 1);
                st_d       = S_WLOW;
            end
            S_WLOW:
            begin
                if (cnt_q == '0)
                begin
                    // Rising write strobe latches the byte held since setup, or since the strobe fell for later address bytes
                    ctl_d.we_n = 1'b1;
                    cnt_d      = CNT_W'(WE_HIGH_CYC - 1);
                    st_d       = S_WHIGH;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            S_WHIGH:
            begin
                if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
                else if (idx_q != last_q)
                begin
                    idx_d      = idx_q + 3'd1;
                    io_d       = {8'h00, addr_byte(req_q, idx_d)}; // RQ3
                    ctl_d.we_n = 1'b0;
                    cnt_d      = CNT_W'(WE_LOW_CYC - 1);
                    st_d       = S_WLOW;
                end
                else
                begin
                    ctl_d.cle   = 1'b0; // RQ2
                    ctl_d.ale   = 1'b0; // RQ3
                    drive_d     = 1'b0;
                    wide_d      = 1'b0;
                    rsp_valid_d = 1'b1;
                    st_d        = S_IDLE;
                end
            end
            S_RLOW:
            begin
                if (cnt_q == '0)
                begin
                    // Low phase spans access time plus the two sync stages
                    rsp_d      = X16 ? io_sync : {8'h00, io_sync[7:0]}; // RQ15
                    ctl_d.re_n = 1'b1;
                    cnt_d      = CNT_W'(RE_HIGH_CYC - 1); // RQ14
                    st_d       = S_RHIGH;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            S_RHIGH:
            begin
                if (cnt_q == '0)
                begin
                    rsp_valid_d = 1'b1;
                    st_d        = S_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            S_SETTLE:
            begin
                // Skip stale ready level until the device has pulled the line
                if (cnt_q == '0)
                begin
                    st_d = S_WAIT;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            S_WAIT:
            begin
                if (rb_sync)
                begin
                    rsp_valid_d = 1'b1; // RQ8
                    st_d        = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q        <= S_IDLE;
            ctl_q       <= CTL_RESET;
            req_q       <= '0;
            cnt_q       <= '0;
            idx_q       <= '0;
            last_q      <= '0;
            io_q        <= '0;
            drive_q     <= 1'b0;
            wide_q      <= 1'b0;
            sel_q       <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end
        else if (i_en)
        begin
            st_q        <= st_d;
            ctl_q       <= ctl_d;
            req_q       <= req_d;
            cnt_q       <= cnt_d;
            idx_q       <= idx_d;
            last_q      <= last_d;
            io_q        <= io_d;
            drive_q     <= drive_d;
            wide_q      <= wide_d;
            sel_q       <= sel_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_q       <= rsp_d;
        end
    end

    // Upper lines stay released unless a 16-bit data word is written
    for (genvar b = 0; b < IO_W; b++)
    begin : g_oe
        if (b < 8)
        begin : g_lo
            assign o_io_bus_oe_n[b] = ~drive_q;
        end
        else
        begin : g_hi
            assign o_io_bus_oe_n[b] = ~(drive_q & wide_q); // RQ15
        end
    end

    assign o_req_ready = (st_q == S_IDLE) && i_en;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_data  = rsp_q;
    assign o_ce_n      = ctl_q.ce_n;
    assign o_cle       = ctl_q.cle;
    assign o_ale       = ctl_q.ale;
    assign o_we_n      = ctl_q.we_n;
    assign o_re_n      = ctl_q.re_n;
    assign o_wp_n      = ctl_q.wp_n;
    assign o_io_bus    = io_q;

endmodule : nfhp_host

`default_nettype wire

// ### sim/nfhp_checker.sv
`timescale 1ns/1ps
`default_nettype none

module nfhp_checker
    import nfhp_pkg::*;
#(
    parameter bit X16 = 1'b0
)
(
    input  wire logic            i_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_en,
    input  wire logic            i_wp_allow,
    input  wire logic            o_rsp_valid,
    input  wire logic            o_ce_n,
    input  wire logic            o_cle,
    input  wire logic            o_ale,
    input  wire logic            o_we_n,
    input  wire logic            o_re_n,
    input  wire logic            o_wp_n,
    input  wire logic [IO_W-1:0] o_io_bus_oe_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    a_latch_excl: assert property (!(o_cle && o_ale))
        else $error("command and address latch high together");
    a_cmd_frame: assert property ($fell(o_we_n) && o_cle |=> o_cle && o_we_n)
        else $error("command latch dropped inside write strobe");
    a_addr_frame: assert property ($fell(o_we_n) && o_ale |=> o_ale && o_we_n)
        else $error("address latch dropped inside write strobe");
    a_latch_sel: assert property (o_cle || o_ale |-> !o_ce_n)
        else $error("latch enable raised while deselected");
    a_we_drive: assert property (!o_we_n |-> o_io_bus_oe_n[7:0] == 8'h00)
        else $error("low byte not driven during write strobe");
    a_read_len: assert property ($fell(o_re_n) |-> !o_re_n [*3] ##1 o_re_n)
        else $error("read strobe low phase not three cycles");
    a_read_float: assert property (!o_re_n |-> &o_io_bus_oe_n)
        else $error("host drives bus during read strobe");
    a_read_done: assert property ($rose(o_re_n) |=> o_rsp_valid)
        else $error("no response after read strobe");
    a_upper_idle: assert property (!X16 |-> &o_io_bus_oe_n[15:8])
        else $error("upper byte driven on byte-wide bus");
    a_wp_follow: assert property ($past(i_rstn, 2) && $past(i_en) |-> o_wp_n == $past(i_wp_allow))
        else $error("write protect pin not following allow input");
endmodule : nfhp_checker

bind nfhp_host nfhp_checker #(.X16(X16)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_en(i_en),
    .i_wp_allow(i_wp_allow), .o_rsp_valid(o_rsp_valid), .o_ce_n(o_ce_n), .o_cle(o_cle),
    .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n),
    .o_io_bus_oe_n(o_io_bus_oe_n));

`default_nettype wire

// ### sim/nfhp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module nfhp_dev_model
#(
    parameter int BUSY_NS = 2000
)
(
    input  wire logic        i_ce_n,
    input  wire logic        i_cle,
    input  wire logic        i_ale,
    input  wire logic        i_we_n,
    input  wire logic        i_re_n,
    input  wire logic        i_wp_n,
    input  wire logic [15:0] i_io,
    output var  logic [15:0] o_io,
    output var  logic        o_rb_oe_n
);
    logic [7:0]  cmd_q    = 8'h00;
    logic [7:0]  din_q    = 8'h00;
    logic [39:0] abus     = 40'h0;
    logic [11:0] col_q    = 12'h000;
    int          acnt     = 0;
    int          prog_cnt = 0;
    event        go;
    initial
    begin
        o_io = 16'h0000;
        o_rb_oe_n = 1'b1;
    end
    always @(posedge i_we_n)
    begin
        if (!i_ce_n && i_cle)
        begin
            cmd_q = i_io[7:0];
            abus = 40'h0;
            acnt = 0;
            // Protected part ignores program and erase confirms
            if ((cmd_q == 8'h10 || cmd_q == 8'hD0) && i_wp_n)
            begin
                prog_cnt++;
                ->go;
            end
            if (cmd_q == 8'h30)
                ->go;
        end
        // Row bytes carry page, plane and block of a 4096 x 64 array
        else if (!i_ce_n && i_ale && acnt < 5)
        begin
            abus[acnt*8 +: 8] = i_io[7:0];
            acnt++;
            if (acnt == 2)
                col_q = abus[11:0];
        end
        else if (!i_ce_n)
            din_q = i_io[7:0];
    end
    // Byte-wide part inverts the upper byte on each read; data sits in the low byte only
    always @(negedge i_re_n)
        if (!i_ce_n)
        begin
            o_io = {~o_io[15:8], col_q[7:0] ^ 8'h5A};
            col_q++;
        end
    // Released bus shows the inverse, so stale data cannot pass
    always @(posedge i_re_n or posedge i_ce_n)
        o_io = ~o_io;
    // Busy ignores chip enable; open drain only pulls low
    always @(go)
    begin
        o_rb_oe_n = 1'b0;
        #(BUSY_NS);
        o_rb_oe_n = 1'b1;
    end
endmodule : nfhp_dev_model

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import nfhp_pkg::*;
;
    typedef struct
    {
        nfhp_op_type op;
        logic [15:0] d;
        logic [11:0] c;
        logic [5:0]  p;
        logic [11:0] b;
        int          k;
        logic [39:0] e;
    } nfhp_tb_row_type;
    logic            i_clk;
    logic            i_rstn;
    logic            i_en;
    logic            i_wp_allow;
    logic            i_req_valid;
    nfhp_req_type    i_req;
    logic            o_req_ready;
    logic            o_rsp_valid;
    logic [IO_W-1:0] o_rsp_data;
    logic            o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n;
    logic [IO_W-1:0] io_out, io_oe_n, io_in, dev_io;
    logic            dev_rb_oe_n, xdev_q, ready_busy_n;
    int              err_total, checked, cyc, n;
    logic [39:0]     a;
    nfhp_tb_row_type rows [16] = '{
        '{OP_CMD,       16'h0000, 12'h000, 6'h00, 12'h000, 1, 40'h00},
        '{OP_ADDR_FULL, 16'h0000, 12'hFFF, 6'h3F, 12'hFFF, 2, 40'h00},
        '{OP_CMD,       16'h0000, 12'h000, 6'h00, 12'h000, 1, 40'h00},
        '{OP_ADDR_FULL, 16'h0000, 12'h0F0, 6'h01, 12'h001, 2, 40'h00},
        '{OP_CMD,       16'h0030, 12'h000, 6'h00, 12'h000, 1, 40'h30},
        '{OP_WAIT,      16'h0000, 12'h000, 6'h00, 12'h000, 0, 40'h00},
        '{OP_READ,      16'h0000, 12'h000, 6'h00, 12'h000, 3, 40'hAA},
        '{OP_READ,      16'h0000, 12'h000, 6'h00, 12'h000, 3, 40'hAB},
        '{OP_CMD,       16'h0005, 12'h000, 6'h00, 12'h000, 1, 40'h05},
        '{OP_ADDR_COL,  16'h0000, 12'h123, 6'h00, 12'h000, 2, 40'h00},
        '{OP_CMD,       16'h00E0, 12'h000, 6'h00, 12'h000, 1, 40'hE0},
        '{OP_READ,      16'h0000, 12'h000, 6'h00, 12'h000, 3, 40'h79},
        '{OP_CMD,       16'h0085, 12'h000, 6'h00, 12'h000, 1, 40'h85},
        '{OP_ADDR_ROW,  16'h0000, 12'h000, 6'h02, 12'h803, 2, 40'h00},
        '{OP_WRITE,     16'hA5C3, 12'h000, 6'h00, 12'h000, 4, 40'hC3},
        '{OP_DESELECT,  16'h0000, 12'h000, 6'h00, 12'h000, 5, 40'h01}};
    assign io_in = (~io_oe_n & io_out) | (io_oe_n & dev_io);
    assign ready_busy_n = dev_rb_oe_n & ~xdev_q;
    nfhp_host #(.X16(1'b0)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_en(i_en),
        .i_wp_allow(i_wp_allow), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
        .i_req(i_req), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_ce_n(o_ce_n),
        .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n),
        .o_io_bus(io_out), .o_io_bus_oe_n(io_oe_n), .i_io_bus(io_in),
        .i_ready_busy_n(ready_busy_n));
    nfhp_dev_model u_flash (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
        .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_io(io_in), .o_io(dev_io),
        .o_rb_oe_n(dev_rb_oe_n));
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk_val(input string s, input logic [39:0] e, input logic [39:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s: expected %h seen %h", s, e, g);
        end
    endtask : chk_val
    task automatic chk_rng(input string s, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi)
        begin
            err_total++;
            $display("wrong value %s: expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask : chk_rng
    // Called just after an edge; leaves just after the edge that shows the response
    task automatic do_op(input nfhp_op_type op, input logic [15:0] d, input logic [11:0] c,
                         input logic [5:0] p, input logic [11:0] b);
        i_req = '{op: op, data: d, col: c, page: p, block: b};
        i_req_valid = 1'b1;
        n = 0;
        while (!o_req_ready && n < 50)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_req_ready !== 1'b1)
        begin
            err_total++;
            $display("wrong value req_ready: expected 1 seen %b", o_req_ready);
            end_sim;
        end
        @(posedge i_clk);
        #1;
        i_req_valid = 1'b0;
        cyc = 0;
        while (o_rsp_valid !== 1'b1 && cyc < 3000)
        begin
            @(posedge i_clk);
            #1;
            cyc++;
        end
        if (o_rsp_valid !== 1'b1)
        begin
            err_total++;
            $display("wrong value rsp_valid: expected 1 seen %b", o_rsp_valid);
            end_sim;
        end
    endtask : do_op
    initial
    begin
        i_rstn = 1'b0;
        i_en = 1'b1;
        i_wp_allow = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        xdev_q = 1'b0;
        err_total = 0;
        checked = 0;
        repeat (10) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        foreach (rows[i])
        begin
            do_op(rows[i].op, rows[i].d, rows[i].c, rows[i].p, rows[i].b);
            a = {6'h0, rows[i].b, rows[i].p, 4'h0, rows[i].c};
            a = rows[i].op == OP_ADDR_ROW ? a >> 16 : rows[i].op == OP_ADDR_COL ? a & 40'hFFFF : a;
            case (rows[i].k)
                1: chk_val("command", rows[i].e, {32'h0, u_flash.cmd_q});
                2: chk_val("address", a, u_flash.abus);
                3: chk_val("read word", rows[i].e, {24'h0, o_rsp_data});
                4: chk_val("data in", rows[i].e, {32'h0, u_flash.din_q});
                5: chk_val("chip select", rows[i].e, {39'h0, o_ce_n});
                default: ;
            endcase
        end
        $display("table test done");
        do_op(OP_CMD, 16'h0080, 12'h0, 6'h0, 12'h0);
        do_op(OP_CMD, 16'h0010, 12'h0, 6'h0, 12'h0);
        do_op(OP_WAIT, 16'h0, 12'h0, 6'h0, 12'h0);
        chk_rng("protected wait", 1, 12, cyc);
        chk_rng("program count", 0, 0, u_flash.prog_cnt);
        i_wp_allow = 1'b1;
        do_op(OP_CMD, 16'h0010, 12'h0, 6'h0, 12'h0);
        chk_val("write protect pin", 40'h1, {39'h0, o_wp_n});
        do_op(OP_WAIT, 16'h0, 12'h0, 6'h0, 12'h0);
        chk_rng("program wait", 40, 60, cyc);
        chk_rng("program count", 1, 1, u_flash.prog_cnt);
        $display("protect test done");
        xdev_q = 1'b1;
        fork
            begin
                repeat (120) @(posedge i_clk);
                #1;
                xdev_q = 1'b0;
            end
        join_none
        do_op(OP_WAIT, 16'h0, 12'h0, 6'h0, 12'h0);
        chk_rng("shared line wait", 115, 130, cyc);
        $display("shared line test done");
        do_op(OP_CMD, 16'h00D0, 12'h0, 6'h0, 12'h0);
        do_op(OP_DESELECT, 16'h0, 12'h0, 6'h0, 12'h0);
        n = 0;
        while (ready_busy_n !== 1'b1 && n < 200)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk_rng("busy while deselected", 40, 60, n);
        $display("deselect test done");
        i_req = '{op: OP_CMD, data: 16'h00FF, col: 12'h0, page: 6'h0, block: 12'h0};
        i_req_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_req_valid = 1'b0;
        @(posedge i_clk);
        #1;
        i_rstn = 1'b0;
        #5;
        chk_val("reset pins", {18'h0, 6'b100110, 16'hFFFF},
                {18'h0, o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, io_oe_n});
        repeat (2) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        do_op(OP_CMD, 16'h0070, 12'h0, 6'h0, 12'h0);
        chk_val("command", 40'h70, {32'h0, u_flash.cmd_q});
        $display("reset test done");
        end_sim;
    end
endmodule : tb

`default_nettype wire
